// ---- src/power_mode_clock_switch.sv ----
// Power-managed mode controller with clock source selection and register slave
`timescale 1ns/1ps
`include "pmcs_regs.svh"
module power_mode_clock_switch
    import pmcs_pkg::*;
(
    // System
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // CPU and wake sources
    input  wire logic        SLEEP_REQ,
    input  wire logic        WAKE_IRQ,
    input  wire logic        WDT_TIMEOUT,
    // Oscillator status pins
    input  wire logic        PRI_READY,
    input  wire logic        SEC_READY,
    input  wire logic        INT_READY,
    // Configuration pins
    input  wire logic        TWO_SPEED_EN,
    input  wire logic        FAIL_SAFE_CLOCK_MONITOR_EN,
    input  wire logic        WDT_EN,
    // Oscillator controls
    output logic             PRI_OSC_EN,
    output logic             SEC_OSC_EN,
    output logic             INT_OSC_EN,
    output logic             LFRC_EN,
    // Clock gating and status
    output logic      [1:0]  SRC_SEL,
    output logic             CPU_CLK_EN,
    output logic             PERIPH_CLK_EN,
    output logic             CPU_READY,
    output logic             DEEP_SLEEP_REQ,
    output logic             PRI_ACTIVE,
    output logic             SEC_RUNNING
);
    localparam logic [3:0] CSD_CYC = 4'(((`CSD_NS * `CLK_MHZ) + 999) / 1000);

    typedef struct packed {
        logic [5:0]  sync1;
        logic [5:0]  sync2;
        mode_t       mode;
        logic [1:0]  cur_src;
        logic [1:0]  tgt_src;
        logic        via_int;
        logic        idle_select;
        logic [1:0]  src_select;
        logic        sec_osc_enable;
        logic        ds_arm;
        logic        ds_req;
        logic [3:0]  csd_cnt;
        logic        sw_req;
        logic        sw_hold;
        logic        ack;
        logic [31:0] dat;
        logic        pri_osc_en;
        logic        int_osc_en;
        logic        lfrc_en;
        logic        cpu_en;
        logic        per_en;
        logic        cpu_ready;
        logic        pri_flag;
        logic        sec_flag;
    } ctrl_t;

    ctrl_t cur_ff;
    ctrl_t nxt_c;

    clk_switch_if sw();

    clock_switch_seq u_seq (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .sw    (sw)
    );

    // Reserved select 10 is treated as the internal block
    function automatic logic [1:0] norm_src(input logic [1:0] s);
        norm_src = (s == 2'h2) ? `SRC_INT : s;
    endfunction

    logic       pri_rdy;
    logic       sec_rdy;
    logic       int_rdy;
    logic       two_speed;
    logic       fail_safe_clock_monitor;
    logic       wdt;
    logic       wake;
    logic       sel_ok;
    logic       wb_req;
    logic [1:0] sel_src;
    logic [1:0] live_src;

    assign pri_rdy   = cur_ff.sync2[0];
    assign sec_rdy   = cur_ff.sync2[1];
    assign int_rdy   = cur_ff.sync2[2];
    assign two_speed = cur_ff.sync2[3];
    assign fail_safe_clock_monitor      = cur_ff.sync2[4];
    assign wdt       = cur_ff.sync2[5];
    assign wake      = WAKE_IRQ | WDT_TIMEOUT;
    assign sel_src   = norm_src(cur_ff.src_select);
    // Source in use, counting a switch that completes this cycle
    assign live_src  = sw.done ? sw.src_sel : cur_ff.cur_src;
    assign sel_ok    = (sel_src != `SRC_SEC) || cur_ff.sec_osc_enable;
    assign wb_req    = WB_CYC_I & WB_STB_I & ~cur_ff.ack;

    always_comb begin
        sw.req        = cur_ff.sw_req;
        sw.target     = cur_ff.tgt_src;
        sw.hold_early = cur_ff.sw_hold;
        case (cur_ff.tgt_src)
            `SRC_PRI: sw.new_ready = pri_rdy;
            `SRC_SEC: sw.new_ready = sec_rdy & cur_ff.sec_osc_enable;
            default:  sw.new_ready = int_rdy;
        endcase
    end

    always_comb begin
        nxt_c        = cur_ff;
        nxt_c.sync1  = {WDT_EN, FAIL_SAFE_CLOCK_MONITOR_EN, TWO_SPEED_EN, INT_READY, SEC_READY, PRI_READY};
        nxt_c.sync2  = cur_ff.sync1;
        nxt_c.sw_req = 1'b0;
        nxt_c.ds_req = 1'b0;

        // Register slave, one wait state
        nxt_c.ack = wb_req;
        if (wb_req) begin
            nxt_c.dat = 32'h0;
            case (WB_ADR_I)
                `OFS_OSC_CTRL: begin
                    nxt_c.dat[`BIT_IDLE_SELECT] = cur_ff.idle_select;
                    nxt_c.dat[`BIT_PRI_ACTIVE]  = cur_ff.pri_flag;
                    nxt_c.dat[1:0]              = cur_ff.src_select;
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        nxt_c.idle_select = WB_DAT_I[`BIT_IDLE_SELECT];
                        nxt_c.src_select  = WB_DAT_I[1:0];
                    end
                end
                `OFS_OSC_CTRL2: begin
                    nxt_c.dat[`BIT_SEC_RUNNING] = cur_ff.sec_flag;
                    nxt_c.dat[`BIT_SEC_OSC_EN]  = cur_ff.sec_osc_enable;
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        nxt_c.sec_osc_enable = WB_DAT_I[`BIT_SEC_OSC_EN];
                    end
                end
                `OFS_PWR_CFG: begin
                    nxt_c.dat[`BIT_DS_ARM] = cur_ff.ds_arm;
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        nxt_c.ds_arm = WB_DAT_I[`BIT_DS_ARM];
                    end
                end
                `OFS_MODE_STAT: begin
                    nxt_c.dat[2:0] = cur_ff.mode;
                    nxt_c.dat[5:4] = cur_ff.cur_src;
                    nxt_c.dat[8]   = sw.busy;
                end
                default: nxt_c.dat = 32'h0;
            endcase
        end

        case (cur_ff.mode)
            M_BOOT: begin
                // Two-speed start runs from internal block while primary warms up;
                // the choice waits until the config pins are through the synchroniser
                nxt_c.csd_cnt = cur_ff.csd_cnt + 4'h1;
                if (cur_ff.csd_cnt == 4'h2) begin
                    nxt_c.tgt_src = two_speed ? `SRC_INT : `SRC_PRI;
                    nxt_c.sw_req  = 1'b1;
                    nxt_c.sw_hold = 1'b1;
                    nxt_c.mode    = M_WAKE;
                    nxt_c.via_int = 1'b0;
                end
            end
            M_RUN: begin
                if (SLEEP_REQ && !sw.busy) begin
                    nxt_c.ds_arm = 1'b0;
                    if (cur_ff.idle_select) begin
                        if (sel_ok) begin
                            nxt_c.mode = M_IDLE;
                            if (sel_src != live_src) begin
                                nxt_c.tgt_src = sel_src;
                                nxt_c.sw_req  = 1'b1;
                                nxt_c.sw_hold = (sel_src == `SRC_SEC);
                            end
                        end
                    end else begin
                        nxt_c.ds_req = cur_ff.ds_arm;
                        nxt_c.mode   = M_SLEEP;
                    end
                end else if (!sw.busy && !cur_ff.sw_req && sel_ok &&
                             sel_src != live_src) begin
                    nxt_c.tgt_src = sel_src;
                    nxt_c.sw_req  = 1'b1;
                    nxt_c.sw_hold = (sel_src == `SRC_SEC);
                end
            end
            M_IDLE: begin
                if (wake && !sw.busy && !cur_ff.sw_req) begin
                    nxt_c.csd_cnt = 4'h0;
                    nxt_c.mode    = M_CSD;
                end
            end
            M_SLEEP: begin
                if (wake) begin
                    nxt_c.via_int = (two_speed | fail_safe_clock_monitor) && sel_src != `SRC_INT;
                    nxt_c.tgt_src = (two_speed | fail_safe_clock_monitor) ? `SRC_INT : sel_src;
                    nxt_c.sw_req  = 1'b1;
                    nxt_c.sw_hold = 1'b1;
                    nxt_c.mode    = M_WAKE;
                end
            end
            M_WAKE: begin
                if (sw.done) begin
                    nxt_c.csd_cnt = 4'h0;
                    nxt_c.mode    = M_CSD;
                end
            end
            M_CSD: begin
                nxt_c.csd_cnt = cur_ff.csd_cnt + 4'h1;
                if (cur_ff.csd_cnt == CSD_CYC - 4'h1) begin
                    nxt_c.mode = M_RUN;
                end
            end
            default: nxt_c.mode = M_RUN;
        endcase

        if (sw.done) begin
            nxt_c.cur_src = sw.src_sel;
        end

        // Outputs follow the mode and the registered current source
        nxt_c.cpu_ready = (cur_ff.mode == M_RUN);
        nxt_c.cpu_en    = (cur_ff.mode == M_RUN) & sw.gate_on;
        nxt_c.per_en    = (cur_ff.mode == M_RUN || cur_ff.mode == M_IDLE ||
                           cur_ff.mode == M_CSD) & sw.gate_on;
        nxt_c.pri_osc_en = (cur_ff.mode != M_SLEEP) &&
                           (cur_ff.cur_src == `SRC_PRI || cur_ff.tgt_src == `SRC_PRI ||
                            cur_ff.mode == M_BOOT);
        nxt_c.int_osc_en = (cur_ff.mode != M_SLEEP) &&
                           (cur_ff.cur_src == `SRC_INT || cur_ff.tgt_src == `SRC_INT);
        nxt_c.lfrc_en    = wdt | fail_safe_clock_monitor | nxt_c.int_osc_en;
        nxt_c.pri_flag   = (cur_ff.mode == M_RUN || cur_ff.mode == M_IDLE ||
                            cur_ff.mode == M_CSD) && cur_ff.cur_src == `SRC_PRI;
        nxt_c.sec_flag   = (cur_ff.mode == M_RUN || cur_ff.mode == M_IDLE ||
                            cur_ff.mode == M_CSD) && cur_ff.cur_src == `SRC_SEC;
        if (cur_ff.mode == M_SLEEP || cur_ff.mode == M_WAKE) begin
            nxt_c.pri_flag = 1'b0;
            nxt_c.sec_flag = 1'b0;
        end
        // Interim internal run after sleep hands over to select in run
        if (cur_ff.mode == M_CSD && cur_ff.via_int) begin
            nxt_c.via_int = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cur_ff <= '{sync1: 6'h00, sync2: 6'h00, mode: M_BOOT,
                        cur_src: `SRC_PRI, tgt_src: `SRC_PRI, via_int: 1'b0,
                        idle_select: `RST_IDLE_SELECT, src_select: `RST_SRC_SELECT,
                        sec_osc_enable: `RST_SEC_OSC_EN, ds_arm: `RST_DS_ARM,
                        ds_req: 1'b0, csd_cnt: 4'h0, sw_req: 1'b0, sw_hold: 1'b0,
                        ack: 1'b0, dat: 32'h0, pri_osc_en: 1'b1, int_osc_en: 1'b0,
                        lfrc_en: 1'b0, cpu_en: 1'b0, per_en: 1'b0, cpu_ready: 1'b0,
                        pri_flag: 1'b0, sec_flag: 1'b0};
        end else begin
            cur_ff <= nxt_c;
        end
    end

    assign WB_DAT_O       = cur_ff.dat;
    assign WB_ACK_O       = cur_ff.ack;
    assign PRI_OSC_EN     = cur_ff.pri_osc_en;
    assign SEC_OSC_EN     = cur_ff.sec_osc_enable;
    assign INT_OSC_EN     = cur_ff.int_osc_en;
    assign LFRC_EN        = cur_ff.lfrc_en;
    assign SRC_SEL        = sw.src_sel;
    assign CPU_CLK_EN     = cur_ff.cpu_en;
    assign PERIPH_CLK_EN  = cur_ff.per_en;
    assign CPU_READY      = cur_ff.cpu_ready;
    assign DEEP_SLEEP_REQ = cur_ff.ds_req;
    assign PRI_ACTIVE     = cur_ff.pri_flag;
    assign SEC_RUNNING    = cur_ff.sec_flag;
endmodule

// ---- src/pmcs_regs.svh ----
// Register offsets, field positions, reset values and timing for the clock switch
`ifndef PMCS_REGS_SVH
`define PMCS_REGS_SVH

`define OFS_OSC_CTRL      8'h00
`define OFS_OSC_CTRL2     8'h04
`define OFS_PWR_CFG       8'h08
`define OFS_MODE_STAT     8'h0c

`define BIT_IDLE_SELECT   7
`define BIT_PRI_ACTIVE    3
`define BIT_SEC_RUNNING   6
`define BIT_SEC_OSC_EN    0
`define BIT_DS_ARM        0

`define RST_IDLE_SELECT   1'b0
`define RST_SRC_SELECT    2'h0
`define RST_SEC_OSC_EN    1'b0
`define RST_DS_ARM        1'b0

`define SRC_PRI           2'h0
`define SRC_SEC           2'h1
`define SRC_INT           2'h3

`define CLK_MHZ           25
`define CSD_NS            200
`define SW_OLD_CYC        2
`define SW_NEW_CYC        4

`endif

// ---- src/pmcs_pkg.sv ----
// Types shared by the power mode and clock switch modules
package pmcs_pkg;
    typedef enum logic [2:0] {
        M_BOOT, M_RUN, M_IDLE, M_SLEEP, M_WAKE, M_CSD
    } mode_t;
    typedef enum logic [2:0] {
        S_IDLE, S_WAIT_LIVE, S_OLD, S_WAIT_HELD, S_NEW
    } sw_state_t;
endpackage

// ---- src/clk_switch_if.sv ----
// Request and status carrier between mode controller and switch sequencer
`timescale 1ns/1ps
interface clk_switch_if;
    logic       req;
    logic [1:0] target;
    logic       hold_early;
    logic       new_ready;
    logic       busy;
    logic       done;
    logic [1:0] src_sel;
    logic       gate_on;
    modport ctrl (output req, target, hold_early, new_ready,
                  input  busy, done, src_sel, gate_on);
    modport seq  (input  req, target, hold_early, new_ready,
                  output busy, done, src_sel, gate_on);
endinterface

// ---- src/clock_switch_seq.sv ----
// Glitch-free clock source switch sequencer
`timescale 1ns/1ps
`include "pmcs_regs.svh"
module clock_switch_seq
    import pmcs_pkg::*;
(
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // Switch request
    clk_switch_if.seq   sw
);
    typedef struct packed {
        sw_state_t  st;
        logic [2:0] cnt;
        logic [1:0] tgt;
        logic [1:0] src;
        logic       gate;
        logic       done;
    } seq_t;

    seq_t cur_ff;
    seq_t nxt_s;

    always_comb begin
        nxt_s      = cur_ff;
        nxt_s.done = 1'b0;
        case (cur_ff.st)
            S_IDLE: begin
                if (sw.req) begin
                    nxt_s.tgt = sw.target;
                    nxt_s.cnt = 3'h0;
                    nxt_s.st  = sw.hold_early ? S_OLD : S_WAIT_LIVE;
                end
            end
            S_WAIT_LIVE: begin
                if (sw.new_ready) begin
                    nxt_s.st = S_OLD;
                end
            end
            S_OLD: begin
                nxt_s.gate = 1'b0;
                nxt_s.cnt  = cur_ff.cnt + 3'h1;
                if (cur_ff.cnt == 3'(`SW_OLD_CYC - 1)) begin
                    nxt_s.src = cur_ff.tgt;
                    nxt_s.cnt = 3'h0;
                    nxt_s.st  = sw.new_ready ? S_NEW : S_WAIT_HELD;
                end
            end
            S_WAIT_HELD: begin
                if (sw.new_ready) begin
                    nxt_s.st = S_NEW;
                end
            end
            S_NEW: begin
                nxt_s.cnt = cur_ff.cnt + 3'h1;
                if (cur_ff.cnt == 3'(`SW_NEW_CYC - 1)) begin
                    nxt_s.gate = 1'b1;
                    nxt_s.done = 1'b1;
                    nxt_s.st   = S_IDLE;
                end
            end
            default: nxt_s.st = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '{st: S_IDLE, cnt: 3'h0, tgt: `SRC_PRI, src: `SRC_PRI,
                        gate: 1'b0, done: 1'b0};
        end else begin
            cur_ff <= nxt_s;
        end
    end

    assign sw.busy    = (cur_ff.st != S_IDLE);
    assign sw.done    = cur_ff.done;
    assign sw.src_sel = cur_ff.src;
    assign sw.gate_on = cur_ff.gate;
endmodule

// ---- dv/pmcs_osc_model.sv ----
// Oscillator stand-in: ready after a start-up count, gone once stopped
`timescale 1ns/1ps
module pmcs_osc_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Oscillator control
    input  wire logic       en,
    input  wire logic [7:0] dly,
    output logic            rdy
);
    logic [7:0] cnt;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            rdy <= 1'b0;
        end else if (!en) begin
            cnt <= 8'h00;
            rdy <= 1'b0;
        end else if (cnt < dly) begin
            cnt <= cnt + 8'h01;
        end else begin
            rdy <= 1'b1;
        end
    end
endmodule

// ---- dv/power_mode_clock_switch_chk.sv ----
// Port-level assertions for the power mode and clock switch block
`timescale 1ns/1ps
module power_mode_clock_switch_chk (
    // System
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    // Wishbone
    input wire logic       WB_CYC_I,
    input wire logic       WB_STB_I,
    input wire logic       WB_ACK_O,
    // Oscillators and config
    input wire logic       SEC_READY,
    input wire logic       WDT_EN,
    input wire logic       FAIL_SAFE_CLOCK_MONITOR_EN,
    input wire logic       LFRC_EN,
    input wire logic       SEC_OSC_EN,
    // Gating and status
    input wire logic [1:0] SRC_SEL,
    input wire logic       CPU_CLK_EN,
    input wire logic       PERIPH_CLK_EN,
    input wire logic       CPU_READY,
    input wire logic       DEEP_SLEEP_REQ,
    input wire logic       PRI_ACTIVE,
    input wire logic       SEC_RUNNING
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_flags_excl; !(PRI_ACTIVE && SEC_RUNNING); endproperty
    a_flags_excl: assert property (p_flags_excl) else $error("both flags set");
    property p_pri_src; $rose(PRI_ACTIVE) |-> SRC_SEL == 2'h0; endproperty
    a_pri_src: assert property (p_pri_src) else $error("primary flag off primary");
    property p_sec_src; $rose(SEC_RUNNING) |-> SRC_SEL == 2'h1; endproperty
    a_sec_src: assert property (p_sec_src) else $error("secondary flag off secondary");
    property p_sec_en; $rose(SRC_SEL == 2'h1) |-> SEC_OSC_EN; endproperty
    a_sec_en: assert property (p_sec_en) else $error("secondary used while disabled");
    property p_sec_wait; (!SEC_READY [*3]) ##0 (SRC_SEL == 2'h1) |-> !PERIPH_CLK_EN; endproperty
    a_sec_wait: assert property (p_sec_wait) else $error("clocked before secondary ready");
    property p_gate; $changed(SRC_SEL) |-> !CPU_CLK_EN && !PERIPH_CLK_EN; endproperty
    a_gate: assert property (p_gate) else $error("source changed while gated on");
    property p_settle; $changed(SRC_SEL) |-> !PERIPH_CLK_EN [*3]; endproperty
    a_settle: assert property (p_settle) else $error("switch settle too short");
    property p_cpu_per; CPU_CLK_EN |-> PERIPH_CLK_EN; endproperty
    a_cpu_per: assert property (p_cpu_per) else $error("cpu clocked without periph");
    property p_lfrc; (WDT_EN || FAIL_SAFE_CLOCK_MONITOR_EN) [*5] |-> LFRC_EN; endproperty
    a_lfrc: assert property (p_lfrc) else $error("low rc stopped");
    property p_rdy_dly; $rose(CPU_READY) |-> !$past(CPU_READY, 5); endproperty
    a_rdy_dly: assert property (p_rdy_dly) else $error("ready delay too short");
    property p_ds_pulse; DEEP_SLEEP_REQ |=> !DEEP_SLEEP_REQ; endproperty
    a_ds_pulse: assert property (p_ds_pulse) else $error("deep sleep pulse too long");
endmodule

bind power_mode_clock_switch power_mode_clock_switch_chk chk_u (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .SEC_READY(SEC_READY), .WDT_EN(WDT_EN), .FAIL_SAFE_CLOCK_MONITOR_EN(FAIL_SAFE_CLOCK_MONITOR_EN),
    .LFRC_EN(LFRC_EN), .SEC_OSC_EN(SEC_OSC_EN), .SRC_SEL(SRC_SEL),
    .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN), .CPU_READY(CPU_READY),
    .DEEP_SLEEP_REQ(DEEP_SLEEP_REQ), .PRI_ACTIVE(PRI_ACTIVE), .SEC_RUNNING(SEC_RUNNING)
);

// ---- dv/power_mode_clock_switch_tb_top.sv ----
// Register-driven bench for the power mode and clock switch block
`timescale 1ns/1ps
module power_mode_clock_switch_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        req = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic        slp = 1'b0, irq = 1'b0, wdt = 1'b0, wdt_en = 1'b1;
    logic        two_sp = 1'b0, fail_safe_clock_monitor_en = 1'b0;
    logic [7:0]  pdly = 8'h10, sdly = 8'h04;
    logic        pri_rdy, sec_rdy, int_rdy, pri_en, sec_en, int_en, lfrc;
    logic        cpu_en, per_en, cpu_rdy, ds, pri_act, secondary_run_mode, ack;
    logic [1:0]  src;
    logic [31:0] dat_o, q;
    int          errors = 0, n_checks = 0, ds_cnt = 0, n;

    power_mode_clock_switch dut_u (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .SLEEP_REQ(slp), .WAKE_IRQ(irq), .WDT_TIMEOUT(wdt), .PRI_READY(pri_rdy),
        .SEC_READY(sec_rdy), .INT_READY(int_rdy), .TWO_SPEED_EN(two_sp), .FAIL_SAFE_CLOCK_MONITOR_EN(fail_safe_clock_monitor_en),
        .WDT_EN(wdt_en), .PRI_OSC_EN(pri_en), .SEC_OSC_EN(sec_en), .INT_OSC_EN(int_en),
        .LFRC_EN(lfrc), .SRC_SEL(src), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en),
        .CPU_READY(cpu_rdy), .DEEP_SLEEP_REQ(ds), .PRI_ACTIVE(pri_act), .SEC_RUNNING(secondary_run_mode)
    );
    pmcs_osc_model pri_u (.clk(clk_sys), .rst_n(rst_n), .en(pri_en), .dly(pdly), .rdy(pri_rdy));
    pmcs_osc_model sec_u (.clk(clk_sys), .rst_n(rst_n), .en(sec_en), .dly(sdly), .rdy(sec_rdy));
    pmcs_osc_model int_u (.clk(clk_sys), .rst_n(rst_n), .en(int_en), .dly(8'h03), .rdy(int_rdy));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (ds === 1'b1) ds_cnt <= ds_cnt + 1;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1 && k++ < 20);
        if (ack !== 1'b1) errors++;
        q = dat_o;
        req <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic pulse(input int s);
        @(posedge clk_sys);
        case (s)
            0: slp <= 1'b1;
            1: irq <= 1'b1;
            default: wdt <= 1'b1;
        endcase
        @(posedge clk_sys);
        slp <= 1'b0;
        irq <= 1'b0;
        wdt <= 1'b0;
    endtask
    function automatic logic hit(input int s);
        case (s)
            0: return cpu_rdy === 1'b1;
            1: return secondary_run_mode === 1'b1;
            2: return pri_act === 1'b1;
            default: return pri_act === 1'b0 && src === 2'h3;
        endcase
    endfunction
    task automatic wait_for(input int s);
        n = 0;
        while (!hit(s) && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 400) errors++;
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge clk_sys);
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        idle(20000);
        errors++;
        end_of_test;
    end

    initial begin
        idle(5);
        rst_n <= 1'b1;
        wait_for(0);
        rd("ctrl", 8'h00, 32'h08);
        chk("pri_active", 32'h1, pri_act);
        rd("status", 8'h0c, 32'h01);
        rd("ctrl2", 8'h04, 32'h00);
        wb(1'b1, 8'h10, 32'h5a);
        rd("unmapped", 8'h10, 32'h0);
        wb(1'b1, 8'h00, 32'h01);
        idle(20);
        chk("src_sel", 32'h0, src);
        chk("pri_active", 32'h1, pri_act);
        sdly <= 8'h28;
        wb(1'b1, 8'h04, 32'h01);
        wb(1'b1, 8'h00, 32'h01);
        idle(20);
        chk("periph_clk_en", 32'h0, per_en);
        wait_for(1);
        idle(4);
        chk("src_sel", 32'h1, src);
        chk("pri_active", 32'h0, pri_act);
        chk("pri_osc_en", 32'h0, pri_en);
        chk("cpu_clk_en", 32'h1, cpu_en);
        rd("ctrl2", 8'h04, 32'h41);
        wb(1'b1, 8'h00, 32'h81);
        pulse(0);
        idle(4);
        chk("cpu_clk_en", 32'h0, cpu_en);
        chk("periph_clk_en", 32'h1, per_en);
        chk("sec_running", 32'h1, secondary_run_mode);
        pulse(1);
        wait_for(0);
        chk("ready delay", 32'h7, n);
        chk("src_sel", 32'h1, src);
        rd("ctrl", 8'h00, 32'h81);
        pdly <= 8'h30;
        wb(1'b1, 8'h00, 32'h80);
        idle(10);
        chk("src_sel", 32'h1, src);
        chk("sec_running", 32'h1, secondary_run_mode);
        wait_for(2);
        chk("sec_running", 32'h0, secondary_run_mode);
        rd("ctrl", 8'h00, 32'h88);
        pulse(0);
        idle(4);
        chk("pri_active", 32'h1, pri_act);
        chk("cpu_clk_en", 32'h0, cpu_en);
        chk("periph_clk_en", 32'h1, per_en);
        pulse(2);
        wait_for(0);
        chk("src_sel", 32'h0, src);
        chk("pri_active", 32'h1, pri_act);
        wb(1'b1, 8'h04, 32'h0);
        wb(1'b1, 8'h00, 32'h81);
        pulse(0);
        idle(6);
        chk("cpu_ready", 32'h1, cpu_rdy);
        chk("src_sel", 32'h0, src);
        wb(1'b1, 8'h00, 32'h03);
        wait_for(3);
        idle(4);
        chk("pri_osc_en", 32'h0, pri_en);
        rd("ctrl", 8'h00, 32'h03);
        pulse(0);
        idle(6);
        chk("cpu_clk_en", 32'h0, cpu_en);
        chk("periph_clk_en", 32'h0, per_en);
        chk("flags", 32'h0, {pri_act, secondary_run_mode});
        chk("int_osc_en", 32'h0, int_en);
        chk("lfrc_en", 32'h1, lfrc);
        wb(1'b0, 8'h0c, 32'h0);
        chk("mode", 32'h3, q & 32'h7);
        pulse(1);
        wait_for(0);
        chk("src_sel", 32'h3, src);
        wb(1'b1, 8'h08, 32'h01);
        pulse(0);
        idle(6);
        pulse(1);
        wait_for(0);
        pulse(0);
        idle(6);
        pulse(1);
        wait_for(0);
        chk("deep sleep pulses", 32'h1, ds_cnt);
        wb(1'b1, 8'h00, 32'h00);
        wait_for(2);
        chk("src_sel", 32'h0, src);
        rd("ctrl", 8'h00, 32'h08);
        wdt_en <= 1'b0;
        fail_safe_clock_monitor_en <= 1'b1;
        pulse(0);
        idle(6);
        chk("lfrc_en", 32'h1, lfrc);
        pulse(1);
        wait_for(0);
        chk("src_sel", 32'h3, src);
        chk("pri_active", 32'h0, pri_act);
        wait_for(2);
        chk("src_sel", 32'h0, src);
        rst_n <= 1'b0;
        two_sp <= 1'b1;
        idle(5);
        rst_n <= 1'b1;
        wait_for(0);
        chk("src_sel", 32'h3, src);
        chk("pri_active", 32'h0, pri_act);
        wait_for(2);
        chk("src_sel", 32'h0, src);
        end_of_test;
    end
endmodule
